// File: include/amrb_params.svh
`ifndef AMRB_PARAMS_SVH
`define AMRB_PARAMS_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define AMRB_CLK_MHZ 40
`define AMRB_PULSE_MS 2
`define AMRB_AUTO_UNIT_US 1000

// ****************************************************************
// Device register offsets on the link
// ****************************************************************
`define AMRB_A_SEQ 6'h00
`define AMRB_A_BUF 6'h02
`define AMRB_A_AUTO 6'h0C
`define AMRB_A_LIM 6'h10
`define AMRB_A_RES 6'h18
`define AMRB_A_FIFO 6'h20

// ****************************************************************
// Device field positions and values
// ****************************************************************
`define AMRB_B_HOSTMODE 4
`define AMRB_B_BUF_EN 0
`define AMRB_B_BUF_CONT 1
`define AMRB_B_BUF_RST 2
`define AMRB_B_AUTO_EN 0
`define AMRB_B_THR_IE 9
`define AMRB_B_FLAG 15
`define AMRB_FIFO_DEPTH 7'h40
`define AMRB_NUM_CH 5

// ****************************************************************
// Host register offsets and field positions on APB
// ****************************************************************
`define AMRB_H_CMD 8'h00
`define AMRB_H_STAT 8'h04
`define AMRB_H_CTRL 8'h08
`define AMRB_B_CMD_WE 24
`define AMRB_B_BUSY 16
`define AMRB_B_IRQN 17
`define AMRB_B_GPIO 18
`define AMRB_B_RSTN 0
`define AMRB_B_PD 1

`endif

// File: include/amrb_pkg.sv
package amrb_pkg;

    // ****************************************************************
    // Conversion sequences and channels
    // ****************************************************************
    typedef enum logic [3:0] {
        SEQ_NONE = 4'h0,
        SEQ_BAT = 4'h1,
        SEQ_AUXILIARY_INPUT_ONE = 4'h2,
        SEQ_AUXILIARY_INPUT_TWO = 4'h3,
        SEQ_SCAN = 4'h4,
        SEQ_XY = 4'h5
    } amrb_seq_t;

    typedef enum logic [2:0] {
        CH_X = 3'h0,
        CH_Y = 3'h1,
        CH_BAT = 3'h2,
        CH_AUXILIARY_INPUT_ONE = 3'h3,
        CH_AUXILIARY_INPUT_TWO = 3'h4
    } amrb_ch_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_WAIT = 3'b100
    } amrb_state_t;

    // ****************************************************************
    // State of the device end
    // ****************************************************************
    typedef struct packed {
        amrb_state_t st;
        amrb_seq_t seq;
        amrb_seq_t set_seq;
        logic host_mode;
        logic [1:0] step;
        logic run;
        logic auto_run;
        logic auto_due;
        logic buf_en;
        logic cont;
        logic [5:0] level;
        logic auto_en;
        logic thr_ie;
        logic [3:0] interval;
        logic thr_flag;
        logic [4:0][11:0] res;
        logic [3:0][11:0] lim;
        logic [63:0][11:0] mem;
        logic [5:0] rd;
        logic [5:0] wr;
        logic [5:0] trg;
        logic [6:0] cnt;
        logic buf_irq;
        logic halt;
        logic [4:0] pend;
        logic [15:0] unit_cnt;
        logic [3:0] ivl_cnt;
        logic [16:0] pulse_cnt;
        logic gpio;
        logic irq_n;
        logic ack;
        logic [15:0] rdata;
        logic adc_start;
        amrb_ch_t adc_ch;
        logic div_on;
        logic pen_en;
    } amrb_dev_t;

    // ****************************************************************
    // State of the host end
    // ****************************************************************
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic req;
        logic we;
        logic [5:0] addr;
        logic [15:0] wdata;
        logic [15:0] last_rdata;
        logic rst_n;
        logic pd;
    } amrb_host_t;

endpackage : amrb_pkg

// File: include/amrb_if.sv
`timescale 1ns/1ps
`default_nettype none

interface amrb_if;
    logic req;
    logic we;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic dev_reset_n;
    logic power_down;
    logic pen_or_data_irq_pin;
    logic general_pin_one;

    modport dev (
        input req, we, addr, wdata, dev_reset_n, power_down,
        output ack, rdata, pen_or_data_irq_pin, general_pin_one
    );
    modport host (
        output req, we, addr, wdata, dev_reset_n, power_down,
        input ack, rdata, pen_or_data_irq_pin, general_pin_one
    );
endinterface : amrb_if

`default_nettype wire

// File: verilog/amrb_device.sv
// Summary of operation
// RQ1 - Battery divider on only while sampling battery
// RQ2 - Non-touch measurements need host-controlled mode
// RQ3 - Auxiliary inputs converted like battery, undivided
// RQ4 - Auto auxiliary conversion on each interval expiry
// RQ5 - Out-of-range auto result sets flag, read clears
// RQ6 - Threshold interrupt enable pulses pin one 2ms
// RQ7 - Port scan converts battery, both auxiliaries
// RQ8 - Circular 64-entry FIFO for all results
// RQ9 - Buffering only when enabled by host
// RQ10 - Read, write and trigger pointers kept
// RQ11 - Trigger level counts single words
// RQ12 - Buffer reset: pointers one, trigger at level
// RQ13 - Results stored in fixed sequence order
// RQ14 - Interrupt pin low when trigger level reached
// RQ15 - Buffering: touch self-controlled, non-touch host-controlled
// RQ16 - Single-shot: halt, resume on first read
// RQ17 - Continuous: rearm, clear on write or read
// RQ18 - Empty read leaves read pointer unchanged
// RQ19 - Full buffer overwrites, read pointer advances
// RQ20 - Empty and full flags with data, status
// RQ21 - Reset pin rise initialises all state
// RQ22 - Power-down keeps registers, disables touch detect
// RQ23 - Data-available low until whole set read
// RQ24 - Pointers wrap from entry 64 to 1
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "amrb_params.svh"

module amrb_device
    import amrb_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `AMRB_PULSE_MS * 1000 * `AMRB_CLK_MHZ,
    parameter int unsigned AUTO_UNIT_CYCLES = `AMRB_AUTO_UNIT_US * `AMRB_CLK_MHZ
) (
    input wire logic pclk,
    input wire logic presetn,
    amrb_if.dev lnk,
    output logic adc_start,
    output logic [2:0] adc_channel,
    output logic divider_on,
    input wire logic adc_done,
    input wire logic [11:0] adc_value,
    input wire logic pen_touch,
    output logic pen_detect_en
);

    // ****************************************************************
    // Reset value and sequence tables
    // ****************************************************************
    localparam amrb_dev_t DEV_RST = '{st: ST_IDLE, seq: SEQ_NONE, set_seq: SEQ_NONE,
        adc_ch: CH_X, irq_n: 1'b1, pen_en: 1'b1, trg: 6'h3F, default: '0};
    localparam logic [16:0] PULSE_LEN = PULSE_CYCLES[16:0];
    localparam logic [15:0] UNIT_LAST = 16'(AUTO_UNIT_CYCLES - 1);

    function automatic amrb_ch_t chan_of(input amrb_seq_t s, input logic [1:0] k);
        case (s)
            SEQ_BAT: chan_of = CH_BAT;
            SEQ_AUXILIARY_INPUT_ONE: chan_of = CH_AUXILIARY_INPUT_ONE;
            SEQ_AUXILIARY_INPUT_TWO: chan_of = CH_AUXILIARY_INPUT_TWO;
            SEQ_SCAN: chan_of = amrb_ch_t'(3'(CH_BAT) + 3'(k)); // RQ7
            SEQ_XY: chan_of = (k == 2'h0) ? CH_Y : CH_X;
            default: chan_of = CH_BAT;
        endcase
    endfunction : chan_of

    function automatic logic [1:0] last_of(input amrb_seq_t s);
        case (s)
            SEQ_SCAN: last_of = 2'h2;
            SEQ_XY: last_of = 2'h1;
            default: last_of = 2'h0;
        endcase
    endfunction : last_of

    amrb_dev_t r_reg;
    amrb_dev_t r_next;
    logic [11:0] v;
    amrb_ch_t ch;
    logic empty;
    logic full;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        v = adc_value;
        ch = r_reg.adc_ch;
        empty = (r_reg.cnt == 7'h00);
        full = (r_reg.cnt == `AMRB_FIFO_DEPTH);
        r_next.ack = 1'b0;
        r_next.adc_start = 1'b0;
        r_next.pen_en = ~lnk.power_down; // RQ22

        // Auto interval timer.
        if (r_reg.unit_cnt == UNIT_LAST) begin
            r_next.unit_cnt = 16'h0000;
            if (r_reg.ivl_cnt == r_reg.interval) begin
                r_next.ivl_cnt = 4'h0;
                r_next.auto_due = r_reg.auto_en; // RQ4
            end else begin
                r_next.ivl_cnt = r_reg.ivl_cnt + 4'h1;
            end
        end else begin
            r_next.unit_cnt = r_reg.unit_cnt + 16'h0001;
        end
        if (r_reg.pulse_cnt != 17'h00000) begin
            r_next.pulse_cnt = r_reg.pulse_cnt - 17'h00001;
        end

        // Link register access: one access per request, answered by ack.
        if (lnk.req && !r_reg.ack) begin
            r_next.ack = 1'b1;
            r_next.rdata = 16'h0000;
            if (lnk.we) begin
                if (lnk.addr == `AMRB_A_SEQ) begin
                    r_next.seq = amrb_seq_t'(lnk.wdata[3:0]);
                    r_next.host_mode = lnk.wdata[`AMRB_B_HOSTMODE];
                    if (lnk.wdata[3:0] == 4'(SEQ_XY)) begin
                        r_next.run = ~lnk.wdata[`AMRB_B_HOSTMODE]; // RQ15
                    end else begin
                        r_next.run = lnk.wdata[`AMRB_B_HOSTMODE]
                            && (lnk.wdata[3:0] != 4'(SEQ_NONE)); // RQ2
                    end
                end else if (lnk.addr == `AMRB_A_BUF) begin
                    r_next.buf_en = lnk.wdata[`AMRB_B_BUF_EN]; // RQ9
                    r_next.cont = lnk.wdata[`AMRB_B_BUF_CONT];
                    r_next.level = lnk.wdata[13:8];
                    if (lnk.wdata[`AMRB_B_BUF_RST] || (lnk.wdata[`AMRB_B_BUF_EN] && !r_reg.buf_en))
                    begin
                        r_next.rd = 6'h00; // RQ12
                        r_next.wr = 6'h00;
                        r_next.trg = lnk.wdata[13:8] - 6'h01;
                        r_next.cnt = 7'h00;
                        r_next.buf_irq = 1'b0;
                        r_next.halt = 1'b0;
                    end
                end else if (lnk.addr == `AMRB_A_AUTO) begin
                    r_next.auto_en = lnk.wdata[`AMRB_B_AUTO_EN];
                    r_next.interval = lnk.wdata[7:4];
                    r_next.thr_ie = lnk.wdata[`AMRB_B_THR_IE];
                end else if (lnk.addr[5:2] == `AMRB_A_LIM >> 2) begin
                    r_next.lim[lnk.addr[1:0]] = lnk.wdata[11:0];
                end
            end else begin
                if (lnk.addr == `AMRB_A_SEQ) begin
                    r_next.rdata = {11'h000, r_reg.host_mode, r_reg.seq};
                end else if (lnk.addr == `AMRB_A_BUF) begin
                    r_next.rdata = {empty, full, r_reg.level, 6'h00,
                        r_reg.cont, r_reg.buf_en}; // RQ20
                end else if (lnk.addr == `AMRB_A_AUTO) begin
                    r_next.rdata = {r_reg.thr_flag, 5'h00, r_reg.thr_ie, 1'b0,
                        r_reg.interval, 3'h0, r_reg.auto_en};
                    r_next.thr_flag = 1'b0; // RQ5
                end else if (lnk.addr[5:2] == `AMRB_A_LIM >> 2) begin
                    r_next.rdata = {4'h0, r_reg.lim[lnk.addr[1:0]]};
                end else if (lnk.addr >= `AMRB_A_RES && lnk.addr < `AMRB_A_RES + 6'h05) begin
                    r_next.rdata = {4'h0, r_reg.res[3'(lnk.addr - `AMRB_A_RES)]};
                    r_next.pend[3'(lnk.addr - `AMRB_A_RES)] = 1'b0; // RQ23
                end else if (lnk.addr == `AMRB_A_FIFO) begin
                    r_next.rdata = {empty, full, 2'h0, r_reg.mem[r_reg.rd]}; // RQ20
                    if (!empty) begin
                        r_next.rd = r_reg.rd + 6'h01; // RQ24
                        r_next.cnt = r_reg.cnt - 7'h01;
                    end // RQ18
                    if (r_reg.halt) begin
                        r_next.halt = 1'b0; // RQ16
                        r_next.buf_irq = 1'b0;
                        r_next.trg = r_reg.trg + r_reg.level;
                    end else if (r_reg.cont) begin
                        r_next.buf_irq = 1'b0; // RQ17
                    end
                end
            end
        end

        // Conversion sequencer.
        case (r_reg.st)
            ST_IDLE: begin
                r_next.step = 2'h0;
                if (r_reg.run && !r_reg.halt && (r_reg.seq != SEQ_XY
                    || (pen_touch && !lnk.power_down))) begin
                    r_next.set_seq = r_reg.seq;
                    r_next.auto_run = 1'b0;
                    r_next.st = ST_START;
                end else if (r_reg.auto_due && r_reg.host_mode && !r_reg.halt) begin
                    r_next.auto_due = 1'b0; // RQ4
                    r_next.set_seq = SEQ_AUXILIARY_INPUT_ONE;
                    r_next.auto_run = 1'b1;
                    r_next.st = ST_START;
                end
            end
            ST_START: begin
                r_next.adc_ch = chan_of(r_reg.set_seq, r_reg.step);
                r_next.adc_start = 1'b1;
                r_next.div_on = (r_next.adc_ch == CH_BAT); // RQ1 RQ3
                r_next.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (adc_done) begin
                    r_next.div_on = 1'b0; // RQ1
                    r_next.res[ch] = v;
                    if (r_reg.buf_en) begin
                        r_next.mem[r_reg.wr] = v; // RQ8 RQ13
                        r_next.wr = r_reg.wr + 6'h01; // RQ10 RQ24
                        if (r_next.cnt == `AMRB_FIFO_DEPTH) begin
                            r_next.rd = r_next.rd + 6'h01; // RQ19
                        end else begin
                            r_next.cnt = r_next.cnt + 7'h01; // RQ11
                        end
                        if (r_reg.cont) begin
                            r_next.buf_irq = 1'b0; // RQ17
                        end
                        if (r_reg.wr == r_next.trg) begin
                            r_next.buf_irq = 1'b1; // RQ14
                            if (r_reg.cont) begin
                                r_next.trg = r_next.trg + r_reg.level; // RQ17
                            end else begin
                                r_next.halt = 1'b1; // RQ16
                            end
                        end
                    end
                    if (r_reg.auto_run && (v > r_reg.lim[0] || v < r_reg.lim[1])) begin
                        r_next.thr_flag = 1'b1; // RQ5
                        if (r_reg.thr_ie) begin
                            r_next.pulse_cnt = PULSE_LEN; // RQ6
                        end
                    end
                    if (!r_reg.buf_en) begin
                        r_next.pend[ch] = 1'b1; // RQ23
                    end
                    if (r_reg.step == last_of(r_reg.set_seq)) begin
                        r_next.st = ST_IDLE;
                        if (!r_reg.buf_en && !r_reg.auto_run) begin
                            r_next.run = 1'b0;
                        end
                    end else begin
                        r_next.step = r_reg.step + 2'h1; // RQ7
                        r_next.st = ST_START;
                    end
                end
            end
            default: r_next.st = ST_IDLE;
        endcase

        // A pending bit only shows once its set has completed.
        if (r_reg.buf_en) begin
            r_next.irq_n = ~r_next.buf_irq; // RQ14
        end else begin
            r_next.irq_n = ~((r_next.st == ST_IDLE) && (r_next.pend != 5'h00)); // RQ23
        end
        r_next.gpio = (r_next.pulse_cnt != 17'h00000); // RQ6

        // Register contents survive power-down; only the reset pin clears them.
        if (!lnk.dev_reset_n) begin
            r_next = DEV_RST; // RQ21
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= DEV_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign lnk.ack = r_reg.ack;
    assign lnk.rdata = r_reg.rdata;
    assign lnk.pen_or_data_irq_pin = r_reg.irq_n;
    assign lnk.general_pin_one = r_reg.gpio;
    assign adc_start = r_reg.adc_start;
    assign adc_channel = r_reg.adc_ch;
    assign divider_on = r_reg.div_on;
    assign pen_detect_en = r_reg.pen_en;

endmodule : amrb_device

`default_nettype wire

// File: verilog/amrb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "amrb_params.svh"

module amrb_host
    import amrb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    amrb_if.host lnk
);

    localparam amrb_host_t HOST_RST = '{default: '0};

    amrb_host_t r_reg;
    amrb_host_t r_next;
    logic setup;
    logic access;
    logic mapped;

    // ****************************************************************
    // APB slave and link master
    // ****************************************************************
    always_comb begin
        r_next = r_reg;
        setup = psel && !penable;
        access = psel && penable && r_reg.pready;
        mapped = (paddr == `AMRB_H_CMD) || (paddr == `AMRB_H_STAT)
            || (paddr == `AMRB_H_CTRL);
        r_next.pready = setup;
        if (setup) begin
            r_next.pslverr = !mapped;
            r_next.prdata = 32'h00000000;
            if (paddr == `AMRB_H_CMD) begin
                r_next.prdata = {7'h00, r_reg.we, 2'h0, r_reg.addr, r_reg.wdata};
            end else if (paddr == `AMRB_H_STAT) begin
                r_next.prdata = {13'h0000, lnk.general_pin_one, lnk.pen_or_data_irq_pin,
                    r_reg.req, r_reg.last_rdata};
            end else if (paddr == `AMRB_H_CTRL) begin
                r_next.prdata = {30'h00000000, r_reg.pd, r_reg.rst_n};
            end
        end
        // A command written while one is in flight is dropped; poll busy first.
        if (access && pwrite) begin
            if (paddr == `AMRB_H_CMD && !r_reg.req) begin
                r_next.req = 1'b1;
                r_next.we = pwdata[`AMRB_B_CMD_WE];
                r_next.addr = pwdata[21:16];
                r_next.wdata = pwdata[15:0];
            end else if (paddr == `AMRB_H_CTRL) begin
                r_next.rst_n = pwdata[`AMRB_B_RSTN]; // RQ21
                r_next.pd = pwdata[`AMRB_B_PD];
            end
        end
        if (r_reg.req && lnk.ack) begin
            r_next.req = 1'b0;
            r_next.last_rdata = lnk.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= HOST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign lnk.req = r_reg.req;
    assign lnk.we = r_reg.we;
    assign lnk.addr = r_reg.addr;
    assign lnk.wdata = r_reg.wdata;
    assign lnk.dev_reset_n = r_reg.rst_n;
    assign lnk.power_down = r_reg.pd;

endmodule : amrb_host

`default_nettype wire

// File: verif/amrb_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Link and pin checks
// ****
module amrb_link_sva #(
    parameter int unsigned PULSE_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic we,
    input wire logic [5:0] addr,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic dev_reset_n,
    input wire logic general_pin_one,
    input wire logic pen_or_data_irq_pin
);
    // The pulse is counted here, since a repetition of that length would be unrolled.
    logic [16:0] hi_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_reg <= 17'h0;
        end else begin
            hi_reg <= general_pin_one ? hi_reg + 17'h1 : 17'h0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reset_quiet: assert property (
        !dev_reset_n |=> pen_or_data_irq_pin && !general_pin_one && !ack)
        else $error("pins active after device reset");
    a_pulse_length: assert property (
        $fell(general_pin_one) |-> hi_reg == PULSE_CYCLES[16:0])
        else $error("threshold pulse length wrong");
    a_pulse_bound: assert property (hi_reg <= PULSE_CYCLES[16:0])
        else $error("threshold pulse too long");
    a_fifo_flags: assert property (
        ack && !we && addr == 6'h20 |-> rdata[13:12] == 2'b00 && !(rdata[15] && rdata[14]))
        else $error("buffer word flags malformed");
    a_ack_single: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    a_req_answered: assert property (req && !ack && dev_reset_n |=> ack)
        else $error("request not answered next cycle");
    a_ack_with_req: assert property (ack |-> req)
        else $error("answer without request");
    a_rdata_holds: assert property (
        !ack && dev_reset_n && $past(dev_reset_n) |-> $stable(rdata))
        else $error("read data moved between answers");
endmodule : amrb_link_sva
`default_nettype wire

// File: verif/amrb_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "amrb_params.svh"
module amrb_bench import amrb_pkg::*;;
    // ****
    // Ends, clock and converter stand-in
    // ****
    typedef struct packed {
        logic [15:0] seq;
        logic [2:0] ch;
        logic conv;
    } amrb_row_t;
    amrb_row_t rows [4] = '{'{16'h0011, CH_BAT, 1'b1}, '{16'h0012, CH_AUXILIARY_INPUT_ONE, 1'b1},
        '{16'h0013, CH_AUXILIARY_INPUT_TWO, 1'b1}, '{16'h0001, CH_BAT, 1'b0}};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, adc_start, divider_on, pen_detect_en;
    logic adc_done = 1'b0;
    logic pen_touch = 1'b0;
    logic [2:0] adc_channel;
    logic [2:0] ch_q = 3'h0;
    logic [2:0] wt = 3'h0;
    logic [11:0] adc_value = 12'h000;
    int mismatches = 0;
    int n_tests = 0;
    amrb_if lnk();
    amrb_host i_amrb_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
    amrb_device #(.PULSE_CYCLES(20), .AUTO_UNIT_CYCLES(8)) i_amrb_device (.pclk(pclk),
        .presetn(presetn), .lnk(lnk.dev), .adc_start(adc_start), .adc_channel(adc_channel),
        .divider_on(divider_on), .adc_done(adc_done), .adc_value(adc_value),
        .pen_touch(pen_touch), .pen_detect_en(pen_detect_en));
    amrb_link_sva #(.PULSE_CYCLES(20)) i_amrb_link_sva (.pclk(pclk), .presetn(presetn),
        .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .ack(lnk.ack), .rdata(lnk.rdata),
        .dev_reset_n(lnk.dev_reset_n), .general_pin_one(lnk.general_pin_one),
        .pen_or_data_irq_pin(lnk.pen_or_data_irq_pin));
    always #12.5 pclk = ~pclk;
    function automatic logic [15:0] val(input logic [2:0] ch);
        return {4'h0, ch, 9'h0A5};
    endfunction : val
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Each conversion takes three cycles, so the divider is seen mid-sample.
    always @(posedge pclk) begin
        adc_done <= (wt == 3'h1);
        adc_value <= {ch_q, 9'h0A5};
        if (adc_start) begin
            ch_q <= adc_channel;
            wt <= 3'h3;
        end else if (wt != 3'h0) begin
            wt <= wt - 3'h1;
        end
        if (wt == 3'h2) chk({15'h0, divider_on}, {15'h0, ch_q == CH_BAT});
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic dev(input logic w, input logic [5:0] a, input logic [15:0] d);
        apb(1'b1, `AMRB_H_CMD, {7'h00, w, 2'b00, a, d});
        do apb(1'b0, `AMRB_H_STAT, 32'h0); while (rd[`AMRB_B_BUSY] !== 1'b0);
    endtask : dev
    task automatic wirq(input logic lvl);
        for (int n = 0; n < 3000 && lnk.pen_or_data_irq_pin !== lvl; n++) @(posedge pclk);
        chk({15'h0, lnk.pen_or_data_irq_pin}, {15'h0, lvl});
    endtask : wirq
    task automatic conclude;
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (40000) @(posedge pclk);
        mismatches++;
        conclude();
    end
    // ****
    // Sequence
    // ****
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `AMRB_H_STAT, 32'h0);
        chk({13'h0, rd[18:16]}, 16'h0002);
        apb(1'b0, 8'h0C, 32'h0);
        chk({er, rd[14:0]}, 16'h8000);
        apb(1'b1, `AMRB_H_CTRL, 32'h1);
        dev(1'b0, `AMRB_A_BUF, 16'h0);
        chk({15'h0, rd[15]}, 16'h1);
        foreach (rows[i]) begin
            dev(1'b1, `AMRB_A_SEQ, rows[i].seq);
            repeat (40) @(posedge pclk);
            wirq(!rows[i].conv);
            if (rows[i].conv) begin
                dev(1'b0, `AMRB_A_RES + 6'(rows[i].ch), 16'h0);
                chk(rd[15:0], val(rows[i].ch));
                wirq(1'b1);
            end
        end
        dev(1'b1, `AMRB_A_SEQ, 16'h0014);
        wirq(1'b0);
        for (int c = 2; c < 5; c++) begin
            chk({15'h0, lnk.pen_or_data_irq_pin}, 16'h0);
            dev(1'b0, `AMRB_A_RES + 6'(c), 16'h0);
            chk(rd[15:0], val(3'(c)));
        end
        wirq(1'b1);
        dev(1'b1, `AMRB_A_LIM, 16'h0100);
        dev(1'b1, `AMRB_A_AUTO, 16'h0231);
        for (int n = 0; n < 3000 && lnk.general_pin_one !== 1'b1; n++) @(posedge pclk);
        chk({15'h0, lnk.general_pin_one}, 16'h1);
        dev(1'b1, `AMRB_A_AUTO, 16'h0200);
        repeat (40) @(posedge pclk);
        dev(1'b0, `AMRB_A_AUTO, 16'h0);
        chk({15'h0, rd[15]}, 16'h1);
        dev(1'b0, `AMRB_A_AUTO, 16'h0);
        chk({15'h0, rd[15]}, 16'h0);
        dev(1'b0, `AMRB_A_RES + 6'h3, 16'h0);
        dev(1'b1, `AMRB_A_BUF, 16'h0401);
        dev(1'b1, `AMRB_A_SEQ, 16'h0011);
        wirq(1'b0);
        repeat (60) @(posedge pclk);
        dev(1'b0, `AMRB_A_BUF, 16'h0);
        chk({14'h0, rd[15:14]}, 16'h0);
        dev(1'b0, `AMRB_A_FIFO, 16'h0);
        chk(rd[15:0], val(CH_BAT));
        wirq(1'b1);
        wirq(1'b0);
        dev(1'b1, `AMRB_A_BUF, 16'h0007);
        dev(1'b0, `AMRB_A_FIFO, 16'h0);
        repeat (1500) @(posedge pclk);
        dev(1'b0, `AMRB_A_BUF, 16'h0);
        chk({15'h0, rd[14]}, 16'h1);
        dev(1'b0, `AMRB_A_FIFO, 16'h0);
        chk({14'h0, rd[15:14]}, 16'h1);
        dev(1'b1, `AMRB_A_SEQ, 16'h0010);
        dev(1'b1, `AMRB_A_BUF, 16'h0);
        repeat (60) @(posedge pclk);
        dev(1'b1, `AMRB_A_BUF, 16'h0405);
        repeat (2) begin
            dev(1'b0, `AMRB_A_FIFO, 16'h0);
            chk({14'h0, rd[15:14]}, 16'h2);
        end
        apb(1'b1, `AMRB_H_CTRL, 32'h3);
        pen_touch <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({15'h0, pen_detect_en}, 16'h0);
        dev(1'b0, `AMRB_A_LIM, 16'h0);
        chk(rd[15:0], 16'h0100);
        dev(1'b1, `AMRB_A_SEQ, 16'h0005);
        repeat (40) @(posedge pclk);
        wirq(1'b1);
        apb(1'b1, `AMRB_H_CTRL, 32'h1);
        wirq(1'b0);
        dev(1'b0, `AMRB_A_RES, 16'h0);
        chk(rd[15:0], val(CH_X));
        apb(1'b1, `AMRB_H_CTRL, 32'h0);
        apb(1'b1, `AMRB_H_CTRL, 32'h1);
        dev(1'b0, `AMRB_A_LIM, 16'h0);
        chk(rd[15:0], 16'h0000);
        conclude();
    end
endmodule : amrb_bench
`default_nettype wire
